//--- rtl/sra_pkg.sv
// sra_pkg: constants and carrier types of the security region attribution block.
// assumes: one 100 MHz clock, 8-bit register offsets taken from the low address byte.
package sra_pkg;
	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int NREG = 8;
	localparam int IDXW = 3;
	localparam int AW = 32;
	localparam int FLD_LSB = 5; // lowest stored address bit
	localparam int FLDW = AW - FLD_LSB;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'hd0;
	localparam logic [7:0] OFF_TYPE = 8'hd4;
	localparam logic [7:0] OFF_SEL = 8'hd8;
	localparam logic [7:0] OFF_BASE = 8'hdc;
	localparam logic [7:0] OFF_LIMIT = 8'he0;
	localparam logic [7:0] OFF_FSTAT = 8'he4;
	localparam logic [7:0] OFF_FADDR = 8'he8;
	localparam logic [7:0] OFF_IRQ_STAT = 8'hf0;
	localparam logic [7:0] OFF_IRQ_MASK = 8'hf4;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_ALLNS_BIT = 1;
	localparam int LIM_NSC_BIT = 1;
	localparam int LIM_EN_BIT = 0;
	localparam int FST_LAZY_STATE_ERROR_BIT = 7;
	localparam int FST_VALID_BIT = 6;
	localparam int SEL_W = 8;
	localparam int IRQ_W = 3;
	localparam int IRQ_LAZY_STATE_ERROR = 0;
	localparam int IRQ_FADDR = 1;
	localparam int IRQ_PRIV = 2;

	// ----------------------------------------
	// implied low bits and reset values
	// ----------------------------------------
	localparam logic [FLD_LSB-1:0] BASE_LOW = 5'h00;
	localparam logic [FLD_LSB-1:0] LIMIT_LOW = 5'h1f;
	localparam logic [1:0] CTRL_RST = 2'h0;
	localparam logic [SEL_W-1:0] SEL_RST = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
	localparam logic [31:0] FADDR_RST = 32'h0000_0000;

	// ----------------------------------------
	// carrier types
	// ----------------------------------------
	typedef struct packed {
		logic [FLDW-1:0] base;
		logic [FLDW-1:0] limit;
		logic nonsecure_callable;
		logic en;
	} sra_region_t;

	typedef struct packed {
		logic secure;
		logic nonsecure_callable;
		logic hit;
	} sra_result_t;
endpackage

//--- rtl/sra_region_mem.sv
// sra_region_mem: table of region base and limit entries with a registered read port.
// assumes: the caller decodes accesses; only the enable bit of each entry is reset.
`timescale 1ns/1ps
module sra_region_mem (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// write port
	input wire logic wr_base,
	input wire logic wr_limit,
	input wire logic [sra_pkg::IDXW-1:0] idx,
	input wire logic [31:0] wdata,
	// read port and table view
	output sra_pkg::sra_region_t rd_data,
	output sra_pkg::sra_region_t [sra_pkg::NREG-1:0] table_out
);
	sra_pkg::sra_region_t entry_reg [sra_pkg::NREG];

	// ----------------------------------------
	// storage, one generated entry per region
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < sra_pkg::NREG; g++) begin : gen_ent
			// enable bit cleared by warm reset, limit write loads it from its bit 0
			always_ff @(posedge mclk) begin
				if (!reset_n) begin
					entry_reg[g].en <= 1'b0;
				end else if (wr_limit && idx == sra_pkg::IDXW'(g)) begin
					entry_reg[g].en <= wdata[sra_pkg::LIM_EN_BIT];
				end
			end
			// address fields and callable bit have no reset value
			always_ff @(posedge mclk) begin
				if (wr_base && idx == sra_pkg::IDXW'(g)) begin
					entry_reg[g].base <= wdata[31:sra_pkg::FLD_LSB];
				end
				if (wr_limit && idx == sra_pkg::IDXW'(g)) begin
					entry_reg[g].limit <= wdata[31:sra_pkg::FLD_LSB];
					entry_reg[g].nonsecure_callable <= wdata[sra_pkg::LIM_NSC_BIT];
				end
			end
			assign table_out[g] = entry_reg[g];
		end
	endgenerate

	// registered read of the selected entry
	always_ff @(posedge mclk) begin
		rd_data <= entry_reg[idx];
	end
endmodule

//--- rtl/sra_attr_unit.sv
// sra_attr_unit: region base/limit registers, fault status and address attribution.
// assumes: a plain register port with read data one cycle after the strobe,
// and core-side event pulses synchronous to mclk.
`timescale 1ns/1ps
module sra_attr_unit (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic reg_secure,
	input wire logic reg_priv,
	output logic [31:0] reg_rdata,
	output logic reg_fault,
	// core events
	input wire logic lazy_err_evt,
	input wire logic fault_addr_evt,
	input wire logic [31:0] fault_addr,
	input wire logic other_fault_evt,
	// attribution check
	input wire logic chk_valid,
	input wire logic [31:0] chk_addr,
	output logic chk_done,
	output sra_pkg::sra_result_t chk_res,
	// interrupt
	output logic irq
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic acc_ok;
	logic acc_bad;
	logic wr_ok;
	logic rd_ok;
	logic [1:0] ctrl_reg;
	logic [sra_pkg::SEL_W-1:0] sel_reg;
	logic lazy_state_error_reg;
	logic valid_reg;
	logic [31:0] faddr_reg;
	logic [sra_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [sra_pkg::IRQ_W-1:0] irq_stat_next;
	logic [sra_pkg::IRQ_W-1:0] irq_mask_reg;
	logic [sra_pkg::IRQ_W-1:0] irq_evt;
	logic rd_valid_reg;
	logic rd_mem_reg;
	logic [7:0] rd_addr_reg;
	logic [31:0] hold_reg;
	logic [31:0] hold_next;
	logic fault_reg;
	logic chk_done_reg;
	sra_pkg::sra_result_t res_reg;
	sra_pkg::sra_result_t res_next;
	sra_pkg::sra_region_t mem_rd;
	sra_pkg::sra_region_t [sra_pkg::NREG-1:0] table_view;
	logic [sra_pkg::NREG-1:0] match_vec;
	logic [sra_pkg::NREG-1:0] nsc_vec;
	logic lsclr;
	logic vclr;

	// ----------------------------------------
	// access qualification
	// ----------------------------------------
	// one set of registers, only the caller's state decides visibility
	assign acc_ok = reg_priv && reg_secure;
	assign acc_bad = (reg_wr || reg_rd) && !reg_priv;
	assign wr_ok = reg_wr && acc_ok;
	assign rd_ok = reg_rd && acc_ok;

	// unprivileged access answered by a fault pulse in the next cycle
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			fault_reg <= 1'b0;
		end else begin
			fault_reg <= acc_bad;
		end
	end
	assign reg_fault = fault_reg;

	// ----------------------------------------
	// region table
	// ----------------------------------------
	sra_region_mem u_mem (
		.mclk(mclk),
		.reset_n(reset_n),
		.wr_base(wr_ok && reg_addr == sra_pkg::OFF_BASE),
		.wr_limit(wr_ok && reg_addr == sra_pkg::OFF_LIMIT),
		.idx(sel_reg[sra_pkg::IDXW-1:0]),
		.wdata(reg_wdata),
		.rd_data(mem_rd),
		.table_out(table_view)
	);

	// ----------------------------------------
	// control and selector registers
	// ----------------------------------------
	// unit enable and all-nonsecure fallback
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			ctrl_reg <= sra_pkg::CTRL_RST;
		end else if (wr_ok && reg_addr == sra_pkg::OFF_CTRL) begin
			ctrl_reg <= reg_wdata[1:0];
		end
	end

	// region selector
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			sel_reg <= sra_pkg::SEL_RST;
		end else if (wr_ok && reg_addr == sra_pkg::OFF_SEL) begin
			sel_reg <= reg_wdata[sra_pkg::SEL_W-1:0];
		end
	end

	// interrupt mask
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			irq_mask_reg <= sra_pkg::IRQ_MASK_RST;
		end else if (wr_ok && reg_addr == sra_pkg::OFF_IRQ_MASK) begin
			irq_mask_reg <= reg_wdata[sra_pkg::IRQ_W-1:0];
		end
	end

	// ----------------------------------------
	// secure fault status and address
	// ----------------------------------------
	assign lsclr = wr_ok && reg_addr == sra_pkg::OFF_FSTAT && reg_wdata[sra_pkg::FST_LAZY_STATE_ERROR_BIT];
	assign vclr = (wr_ok && reg_addr == sra_pkg::OFF_FSTAT && reg_wdata[sra_pkg::FST_VALID_BIT])
		|| other_fault_evt;

	// lazy state error, sticky, write one to clear, a new error wins
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			lazy_state_error_reg <= 1'b0;
		end else if (lazy_err_evt) begin
			lazy_state_error_reg <= 1'b1;
		end else if (lsclr) begin
			lazy_state_error_reg <= 1'b0;
		end
	end

	// fault address valid, dropped by other fault types or a write of one
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			valid_reg <= 1'b0;
		end else if (fault_addr_evt) begin
			valid_reg <= 1'b1;
		end else if (vclr) begin
			valid_reg <= 1'b0;
		end
	end

	// fault address, captured by the core or written by software
	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			faddr_reg <= sra_pkg::FADDR_RST;
		end else if (fault_addr_evt) begin
			faddr_reg <= fault_addr;
		end else if (wr_ok && reg_addr == sra_pkg::OFF_FADDR) begin
			faddr_reg <= reg_wdata;
		end
	end

	// ----------------------------------------
	// interrupt status, cleared by reading it
	// ----------------------------------------
	always_comb begin
		irq_evt = '0;
		irq_evt[sra_pkg::IRQ_LAZY_STATE_ERROR] = lazy_err_evt;
		irq_evt[sra_pkg::IRQ_FADDR] = fault_addr_evt;
		irq_evt[sra_pkg::IRQ_PRIV] = acc_bad;
		irq_stat_next = irq_stat_reg;
		if (rd_ok && reg_addr == sra_pkg::OFF_IRQ_STAT) begin
			irq_stat_next = '0;
		end
		irq_stat_next = irq_stat_next | irq_evt; // set wins over the read clear
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= irq_stat_next;
		end
	end
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// ----------------------------------------
	// register read path
	// ----------------------------------------
	// value of every non-table register, caught at the read strobe
	always_comb begin
		hold_next = 32'h0000_0000;
		unique case (reg_addr)
			sra_pkg::OFF_CTRL: hold_next[1:0] = ctrl_reg;
			sra_pkg::OFF_TYPE: hold_next[sra_pkg::SEL_W-1:0] = 8'(sra_pkg::NREG);
			sra_pkg::OFF_SEL: hold_next[sra_pkg::SEL_W-1:0] = sel_reg;
			sra_pkg::OFF_FSTAT: begin
				hold_next[sra_pkg::FST_LAZY_STATE_ERROR_BIT] = lazy_state_error_reg;
				hold_next[sra_pkg::FST_VALID_BIT] = valid_reg;
			end
			sra_pkg::OFF_FADDR: hold_next = faddr_reg;
			sra_pkg::OFF_IRQ_STAT: hold_next[sra_pkg::IRQ_W-1:0] = irq_stat_reg;
			sra_pkg::OFF_IRQ_MASK: hold_next[sra_pkg::IRQ_W-1:0] = irq_mask_reg;
			default: hold_next = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			rd_valid_reg <= 1'b0;
			rd_mem_reg <= 1'b0;
			rd_addr_reg <= 8'h00;
			hold_reg <= 32'h0000_0000;
		end else begin
			rd_valid_reg <= rd_ok;
			rd_mem_reg <= reg_addr == sra_pkg::OFF_BASE || reg_addr == sra_pkg::OFF_LIMIT;
			rd_addr_reg <= reg_addr;
			hold_reg <= hold_next;
		end
	end

	// read data only in the cycle after an accepted read
	always_comb begin
		reg_rdata = 32'h0000_0000;
		if (rd_valid_reg && rd_mem_reg && rd_addr_reg == sra_pkg::OFF_BASE) begin
			reg_rdata = {mem_rd.base, sra_pkg::BASE_LOW};
		end else if (rd_valid_reg && rd_mem_reg) begin
			reg_rdata = {mem_rd.limit, 3'h0, mem_rd.nonsecure_callable, mem_rd.en};
		end else if (rd_valid_reg) begin
			reg_rdata = hold_reg;
		end
	end

	// ----------------------------------------
	// address attribution
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < sra_pkg::NREG; g++) begin : gen_match
			// expanded bounds, both inclusive, only for enabled regions
			assign match_vec[g] = table_view[g].en
				&& chk_addr >= {table_view[g].base, sra_pkg::BASE_LOW}
				&& chk_addr <= {table_view[g].limit, sra_pkg::LIMIT_LOW};
			assign nsc_vec[g] = match_vec[g] && table_view[g].nonsecure_callable;
		end
	endgenerate

	// one match gives its attribute, several matches fall back to secure
	always_comb begin
		res_next = '0;
		if (!ctrl_reg[sra_pkg::CTRL_EN_BIT]) begin
			res_next.secure = !ctrl_reg[sra_pkg::CTRL_ALLNS_BIT];
		end else if (match_vec != '0 && (match_vec & (match_vec - 1'b1)) == '0) begin
			res_next.hit = 1'b1;
			res_next.nonsecure_callable = |nsc_vec;
			res_next.secure = |nsc_vec;
		end else begin
			res_next.hit = match_vec != '0;
			res_next.secure = 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			chk_done_reg <= 1'b0;
			res_reg <= '0;
		end else begin
			chk_done_reg <= chk_valid;
			if (chk_valid) begin
				res_reg <= res_next;
			end
		end
	end
	assign chk_done = chk_done_reg;
	assign chk_res = res_reg;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	AST_NS_RAZ: assert property (reg_rd && reg_priv && !reg_secure |=> reg_rdata == 32'h0000_0000)
		else $error("nonsecure read returned data");
	AST_NS_WI: assert property (reg_wr && !reg_secure && reg_addr == sra_pkg::OFF_SEL |=> $stable(sel_reg))
		else $error("nonsecure write changed selector");
	AST_PRIV_FAULT: assert property (acc_bad |=> reg_fault)
		else $error("unprivileged access without fault");
	AST_NO_FAULT: assert property (!acc_bad |=> !reg_fault)
		else $error("fault without unprivileged access");
	AST_PRIV_RAZ: assert property (acc_bad && reg_rd |=> reg_rdata == 32'h0000_0000)
		else $error("unprivileged read returned data");
	AST_BASE_LOW: assert property (rd_ok && reg_addr == sra_pkg::OFF_BASE |=> reg_rdata[4:0] == 5'h00)
		else $error("base low bits not zero");
	AST_LIMIT_BACK: assert property (wr_ok && reg_addr == sra_pkg::OFF_LIMIT ##1 rd_ok
		&& reg_addr == sra_pkg::OFF_LIMIT && $stable(sel_reg)
		|=> reg_rdata == ($past(reg_wdata, 2) & 32'hffff_ffe3))
		else $error("limit readback mismatch");
	AST_EN_RESET: assert property ($rose(reset_n) |-> table_view[0].en == 1'b0)
		else $error("region enable not cleared by reset");
	AST_LAZY_STATE_ERROR_SET: assert property (lazy_err_evt |=> lazy_state_error_reg)
		else $error("lazy state error not latched");
	AST_LAZY_STATE_ERROR_HOLD: assert property (lazy_state_error_reg && !lsclr |=> lazy_state_error_reg)
		else $error("lazy state error not held");
	AST_VALID_SET: assert property (fault_addr_evt |=> valid_reg && faddr_reg == $past(fault_addr))
		else $error("fault address not captured");
	AST_VALID_CLR: assert property (other_fault_evt && !fault_addr_evt |=> !valid_reg)
		else $error("valid flag survived other fault");
	AST_SEL_RD: assert property (wr_ok && reg_addr == sra_pkg::OFF_SEL |=> sel_reg == $past(reg_wdata[7:0]))
		else $error("selector write lost");
	AST_CHK_NS: assert property (chk_valid && ctrl_reg[sra_pkg::CTRL_EN_BIT] && match_vec == '0
		|=> chk_done && chk_res.secure && !chk_res.hit)
		else $error("unmatched address not secure");
	// overlapping enabled regions take the most secure attribute
	AST_OVERLAP: assert property (chk_valid && ctrl_reg[sra_pkg::CTRL_EN_BIT]
		&& (match_vec & (match_vec - 1'b1)) != '0
		|=> chk_res.secure && chk_res.hit && !chk_res.nonsecure_callable)
		else $error("overlapping regions not secure");

	COV_NS_HIT: cover property (chk_done && chk_res.hit && !chk_res.secure);
	COV_NSC_HIT: cover property (chk_done && chk_res.nonsecure_callable);
	COV_LAZY_STATE_ERROR_IRQ: cover property (lazy_err_evt ##1 irq);
	COV_PRIV: cover property (reg_fault);
	COV_OVERLAP: cover property (chk_done && chk_res.hit && chk_res.secure && !chk_res.nonsecure_callable);
endmodule

//--- tb/sra_core_model.sv
// sra_core_model: core-side partner that raises fault events and asks for attribution checks.
// assumes: driven through its tasks by the bench; changes only just after rising edges.
`timescale 1ns/1ps
module sra_core_model (
	// clock
	input wire logic mclk,
	// core events
	output logic lazy_err_evt,
	output logic fault_addr_evt,
	output logic [31:0] fault_addr,
	output logic other_fault_evt,
	// attribution check
	output logic chk_valid,
	output logic [31:0] chk_addr,
	input wire logic chk_done,
	input wire sra_pkg::sra_result_t chk_res
);
	// idle at time zero
	initial begin
		lazy_err_evt = 1'b0;
		fault_addr_evt = 1'b0;
		other_fault_evt = 1'b0;
		fault_addr = 32'h0000_0000;
		chk_valid = 1'b0;
		chk_addr = 32'h0000_0000;
	end

	// one-cycle event pulse: 0 lazy error, 1 fault with address, 2 other exception
	task automatic pulse(input int k, input logic [31:0] a);
		@(posedge mclk);
		lazy_err_evt <= (k == 0);
		fault_addr_evt <= (k == 1);
		other_fault_evt <= (k == 2);
		fault_addr <= a;
		@(posedge mclk);
		lazy_err_evt <= 1'b0;
		fault_addr_evt <= 1'b0;
		other_fault_evt <= 1'b0;
		fault_addr <= ~a; // stale address must not be relied on
	endtask

	// one request, answer taken in the cycle after it
	task automatic check(input logic [31:0] a, output sra_pkg::sra_result_t r, output logic d);
		@(posedge mclk);
		chk_valid <= 1'b1;
		chk_addr <= a;
		@(posedge mclk);
		chk_valid <= 1'b0;
		chk_addr <= ~a;
		#1;
		r = chk_res;
		d = chk_done;
	endtask
endmodule

//--- tb/tb.sv
// tb: self-checking bench of the region attribution block.
// assumes: one 100 MHz clock, synchronous active-low reset, core side from sra_core_model.
`timescale 1ns/1ps
module tb;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic reg_secure = 1'b0;
	logic reg_priv = 1'b0;
	logic [31:0] reg_rdata;
	logic reg_fault;
	logic lazy_err_evt, fault_addr_evt, other_fault_evt, chk_valid, chk_done, irq;
	logic [31:0] fault_addr, chk_addr;
	sra_pkg::sra_result_t chk_res;
	logic last_fault;
	int bad_count = 0;
	int n_tests = 0;

	sra_attr_unit dut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_secure(reg_secure),
		.reg_priv(reg_priv), .reg_rdata(reg_rdata), .reg_fault(reg_fault),
		.lazy_err_evt(lazy_err_evt), .fault_addr_evt(fault_addr_evt), .fault_addr(fault_addr),
		.other_fault_evt(other_fault_evt), .chk_valid(chk_valid), .chk_addr(chk_addr),
		.chk_done(chk_done), .chk_res(chk_res), .irq(irq));
	sra_core_model core (.mclk(mclk), .lazy_err_evt(lazy_err_evt),
		.fault_addr_evt(fault_addr_evt), .fault_addr(fault_addr),
		.other_fault_evt(other_fault_evt), .chk_valid(chk_valid), .chk_addr(chk_addr),
		.chk_done(chk_done), .chk_res(chk_res));

	// clock
	always #5 mclk = ~mclk;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic results;
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
		n_tests++;
		if (g !== e) begin
			$display("ERROR %0t %s got %h want %h", $time, m, g, e);
			bad_count++;
		end
	endtask

	// one-cycle word write, fault flag taken in the following cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic s = 1, p = 1);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		reg_secure <= s;
		reg_priv <= p;
		@(posedge mclk);
		reg_wr <= 1'b0;
		#1;
		last_fault = reg_fault;
	endtask

	// one-cycle word read, data taken only in the following cycle
	task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic s = 1, p = 1);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		reg_secure <= s;
		reg_priv <= p;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
		last_fault = reg_fault;
	endtask

	// write then read with no gap between the strobes
	task automatic wr_rd(input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= wd;
		reg_wr <= 1'b1;
		reg_secure <= 1'b1;
		reg_priv <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		d = reg_rdata;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		logic [31:0] d;
		rd(sra_pkg::OFF_LIMIT, d);
		cmp({31'h0, d[0]}, 32'h0000_0000, "region enable after reset");
		rd(sra_pkg::OFF_FSTAT, d);
		cmp(d, 32'h0000_0000, "fault status after reset");
		cmp({31'h0, irq}, 32'h0000_0000, "irq after reset");
		rd(sra_pkg::OFF_TYPE, d);
		cmp(d, 32'(sra_pkg::NREG), "region count");
	endtask

	task automatic t_regs;
		logic [31:0] d;
		wr(sra_pkg::OFF_SEL, 32'h0000_0003);
		wr(sra_pkg::OFF_BASE, 32'h1234_567f);
		wr_rd(sra_pkg::OFF_LIMIT, 32'habcd_ef7f, d);
		cmp(d, 32'habcd_ef63, "limit back to back");
		wr(sra_pkg::OFF_SEL, 32'h0000_0005);
		wr(sra_pkg::OFF_BASE, 32'h0bad_0000);
		wr(sra_pkg::OFF_LIMIT, 32'h0bad_1000);
		rd(sra_pkg::OFF_BASE, d);
		cmp(d, 32'h0bad_0000, "base of region 5");
		wr(sra_pkg::OFF_SEL, 32'h0000_0003);
		rd(sra_pkg::OFF_BASE, d);
		cmp(d, 32'h1234_5660, "base of region 3");
		rd(sra_pkg::OFF_LIMIT, d);
		cmp(d, 32'habcd_ef63, "limit of region 3");
	endtask

	task automatic t_nonsecure;
		logic [31:0] d;
		wr(sra_pkg::OFF_BASE, 32'hffff_ffe0, 0, 1);
		cmp({31'h0, last_fault}, 32'h0000_0000, "nonsecure write faulted");
		wr(sra_pkg::OFF_SEL, 32'h0000_0005, 0, 1);
		rd(sra_pkg::OFF_BASE, d, 0, 1);
		cmp(d, 32'h0000_0000, "nonsecure read");
		rd(sra_pkg::OFF_BASE, d);
		cmp(d, 32'h1234_5660, "base after nonsecure write");
	endtask

	task automatic t_priv;
		logic [31:0] d;
		wr(sra_pkg::OFF_BASE, 32'h0000_0000, 1, 0);
		cmp({31'h0, last_fault}, 32'h0000_0001, "unprivileged write fault");
		rd(sra_pkg::OFF_BASE, d, 1, 0);
		cmp({d[31:1], last_fault}, 32'h0000_0001, "unprivileged read");
		rd(sra_pkg::OFF_BASE, d);
		cmp(d, 32'h1234_5660, "base after unprivileged write");
		cmp({31'h0, irq}, 32'h0000_0000, "irq while masked");
		wr(sra_pkg::OFF_IRQ_MASK, 32'h0000_0004);
		@(posedge mclk);
		#1;
		cmp({31'h0, irq}, 32'h0000_0001, "irq after unmask");
		rd(sra_pkg::OFF_IRQ_STAT, d);
		cmp(d, 32'h0000_0004, "irq status");
		@(posedge mclk);
		#1;
		cmp({31'h0, irq}, 32'h0000_0000, "irq after status read");
	endtask

	task automatic t_events;
		logic [31:0] d;
		core.pulse(0, 32'h0000_0000);
		rd(sra_pkg::OFF_FSTAT, d);
		cmp(d, 32'h0000_0080, "lazy error flag");
		rd(sra_pkg::OFF_FSTAT, d);
		cmp(d, 32'h0000_0080, "lazy error flag sticky");
		wr(sra_pkg::OFF_FSTAT, 32'h0000_0080);
		rd(sra_pkg::OFF_FSTAT, d);
		cmp(d, 32'h0000_0000, "lazy error cleared");
		core.pulse(1, 32'hcafe_0040);
		rd(sra_pkg::OFF_FSTAT, d);
		cmp(d, 32'h0000_0040, "address valid flag");
		rd(sra_pkg::OFF_FADDR, d);
		cmp(d, 32'hcafe_0040, "fault address");
		core.pulse(2, 32'h0000_0000);
		rd(sra_pkg::OFF_FSTAT, d);
		cmp(d, 32'h0000_0000, "valid cleared by other fault");
		cmp({31'h0, irq}, 32'h0000_0000, "event irq masked");
		rd(sra_pkg::OFF_IRQ_STAT, d);
		cmp(d, 32'h0000_0003, "event irq status");
	endtask

	task automatic t_attr;
		logic [31:0] a [4] = '{32'h1234_5660, 32'habcd_ef7f, 32'h1234_565f, 32'habcd_ef80};
		logic [2:0] e [4] = '{3'b111, 3'b111, 3'b100, 3'b100};
		sra_pkg::sra_result_t r;
		logic dn;
		wr(sra_pkg::OFF_CTRL, 32'h0000_0002);
		core.check(32'h1234_5660, r, dn);
		cmp({28'h0, dn, r}, 32'h0000_0008, "unit off, all nonsecure");
		wr(sra_pkg::OFF_CTRL, 32'h0000_0001);
		for (int i = 0; i < 4; i++) begin
			core.check(a[i], r, dn);
			cmp({28'h0, dn, r}, {28'h0, 1'b1, e[i]}, "bounds check");
		end
		wr(sra_pkg::OFF_LIMIT, 32'habcd_ef61);
		core.check(32'h1234_5660, r, dn);
		cmp({28'h0, dn, r}, 32'h0000_0009, "region not callable");
		wr(sra_pkg::OFF_SEL, 32'h0000_0005);
		wr(sra_pkg::OFF_BASE, 32'h1234_5600);
		wr(sra_pkg::OFF_LIMIT, 32'h1234_5661);
		core.check(32'h1234_5660, r, dn);
		cmp({28'h0, dn, r}, 32'h0000_000d, "overlap falls back to secure");
		wr(sra_pkg::OFF_SEL, 32'h0000_0003);
		wr(sra_pkg::OFF_LIMIT, 32'habcd_ef62);
		core.check(32'habcd_ef7f, r, dn);
		cmp({28'h0, dn, r}, 32'h0000_000c, "region disabled");
	endtask

	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge mclk);
		reset_n <= 1'b1;
		t_reset();
		t_regs();
		t_nonsecure();
		t_priv();
		t_events();
		t_attr();
		results();
	end

	initial begin
		#200000;
		$display("ERROR %0t run did not finish", $time);
		bad_count++;
		results();
	end
endmodule
